// file: inc/sri_pkg.sv
// constants, field layouts and types for the spi register interface
// Functional notes
// - enable bit gates done, fault, overrun interrupt
// - enable resets low, pins free, cleared on fault
// - master bit drives clock, cleared on fault
// - polarity bit sets clock idle level
// - phase bit picks first or second capture edge
// - master clock divided per rate bits table
// - rate bits ignored in slave mode
// - done flag set per byte, status-then-data clear
// - data writes ignored while done until status read or write
// - write during transfer sets collision, transfer continues
// - byte ready while done set sets overrun
// - select low in master sets fault, status-then-control clear
// - output disable releases mosi or miso driver
// - select management uses internal bit, ignores pin
// - internal select bit zero means selected
// - data write loads shifter, starts master transfer
// - received byte copied to buffer, reads see buffer
// - reset clears upper control bits and status
// - fault blocks setting enable and master bits
// - on overrun buffer keeps first byte, later dropped
// - collision flag never raises interrupt
package sri_pkg;

   // register indices as printed, byte address is four times the index
   localparam logic [7:0] IDX_DATA = 8'h31;
   localparam logic [7:0] IDX_CTRL = 8'h32;
   localparam logic [7:0] IDX_STAT = 8'h33;
   localparam logic [9:0] ADDR_DATA = {IDX_DATA, 2'b00};
   localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [9:0] ADDR_STAT = {IDX_STAT, 2'b00};

   // status register field positions
   localparam int STAT_DONE = 7;
   localparam int STAT_WRITE_COLLISION_FLAG = 6;
   localparam int STAT_OVR  = 5;
   localparam int STAT_MODE_FAULT_FLAG = 4;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] SW_STAT_RST = 3'h0;
   localparam logic [7:0] DATA_RST = 8'h00;

   // byte framing: last sck edge index and last sample index
   localparam logic [3:0] LAST_EDGE   = 4'hf;
   localparam logic [2:0] LAST_SAMPLE = 3'h7;

   // master half-period counts in cpu clocks, one per divide ratio
   localparam logic [6:0] HALF_DIV4   = 7'h02;
   localparam logic [6:0] HALF_DIV8   = 7'h04;
   localparam logic [6:0] HALF_DIV16  = 7'h08;
   localparam logic [6:0] HALF_DIV32  = 7'h10;
   localparam logic [6:0] HALF_DIV64  = 7'h20;
   localparam logic [6:0] HALF_DIV128 = 7'h40;

   // control register, field order matches the bit order 7..0
   typedef struct packed {
      logic       irq_en;      // interrupt_enable_bit
      logic       periph_en;   // peripheral_enable_bit
      logic       div_dis;     // divider_disable_bit
      logic       master;      // master_select_bit
      logic       clock_polarity_bit;        // clock_polarity_bit
      logic       clock_phase_bit;        // clock_phase_bit
      logic [1:0] rate;        // rate_select_bits
   } sri_ctrl_t;

   // software bits of the status register, bits 2..0
   typedef struct packed {
      logic out_dis;           // output_disable_bit
      logic sel_mgmt;          // select_management_bit
      logic sel_int;           // internal_select_bit
   } sri_swstat_t;

   // master sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01
   } sri_state_t;

endpackage

// file: hw/sri_core.sv
// spi peripheral with ahb-lite register slave and serial pin logic
`timescale 1ns/1ps
module sri_core
   import sri_pkg::*;
#(
   parameter int ADDR_W = 32                  // ahb address width
)(
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   // ahb-lite slave
   input  wire logic              hsel_i,
   input  wire logic [ADDR_W-1:0] haddr_i,
   input  wire logic [1:0]        htrans_i,
   input  wire logic              hwrite_i,
   input  wire logic [2:0]        hsize_i,
   input  wire logic [31:0]       hwdata_i,
   input  wire logic              hready_i,
   output logic      [31:0]       hrdata_o,
   output logic                   hreadyout_o,
   output logic                   hresp_o,
   // serial pins
   input  wire logic              sck_i,
   output logic                   sck_o,
   output logic                   sck_oe_o,
   input  wire logic              mosi_i,
   output logic                   mosi_o,
   output logic                   mosi_oe_o,
   input  wire logic              miso_i,
   output logic                   miso_o,
   output logic                   miso_oe_o,
   input  wire logic              ss_n_i,
   // interrupt request
   output logic                   irq_o
);

   // register state
   sri_ctrl_t   ctrl;                 // control register
   sri_swstat_t swst;                 // software part of status
   logic        done_flag;            // transfer_done_flag
   logic        write_collision_flag_flag;            // write_collision_flag
   logic        ovr_flag;             // overrun_flag
   logic        mode_fault_flag_flag;            // mode_fault_flag
   logic [7:0]  rx_buf;               // receive buffer seen by reads
   logic        td_seen;              // status accessed while done set
   logic        wc_seen;              // status read while collision set
   logic        mf_seen;              // status accessed while fault set

   // bus phase tracking
   logic        wr_pend;              // write data phase pending
   logic [9:0]  wr_addr;              // address of pending write
   logic        acc;                  // address phase accepted
   logic        rd_data, rd_stat;     // read strobes, address phase
   logic        stat_acc;             // status accessed (read or write)
   logic        wr_data, wr_ctrl, wr_stat;

   // synchronisers for pin inputs
   logic        sck_s1, sck_s2, sck_s3;
   logic        mosi_s1, mosi_s2;
   logic        miso_s1, miso_s2;
   logic        ss_s1, ss_s2;

   // shifter and sequencing
   sri_state_t  state;                // master sequencer
   logic [6:0]  div_cnt;              // half-period counter
   logic [6:0]  half;                 // selected half period
   logic [3:0]  edge_cnt;             // master sck edge count
   logic [2:0]  smp_cnt;              // bits sampled so far
   logic [7:0]  shreg;                // shift register
   logic        out_bit;              // bit presented on the output pin
   logic        msck;                 // master clock level
   logic        slv_busy;             // slave byte in flight
   logic        sel_n;                // effective slave select, low active
   logic        slv_act;              // slave enabled and selected
   logic        m_tick, edge_v, edge_lead, smp, shf;
   logic        rx_in, m_done, s_done, xfer_done, busy;
   logic        fault, wr_ok;
   logic [7:0]  next_shreg;
   logic [7:0]  rd_byte;
   logic        m_cap;                // master capture, one cycle late
   logic        m_fin;                // master byte end, one cycle after the last edge
   logic        cap;                  // shift-in strobe for either mode

   // zero-wait slave, always okay
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   // address phase decode; reads act here so data and side effect agree
   assign acc      = hsel_i & htrans_i[1] & hready_i;
   assign rd_data  = acc & ~hwrite_i & (haddr_i[9:0] == ADDR_DATA);
   assign rd_stat  = acc & ~hwrite_i & (haddr_i[9:0] == ADDR_STAT);
   assign wr_data  = wr_pend & (wr_addr == ADDR_DATA);
   assign wr_ctrl  = wr_pend & (wr_addr == ADDR_CTRL);
   assign wr_stat  = wr_pend & (wr_addr == ADDR_STAT);
   assign stat_acc = rd_stat | wr_stat;

   // capture write address phase for the following data phase
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 10'h000;
      end
      else
      begin
         wr_pend <= acc & hwrite_i;
         wr_addr <= haddr_i[9:0];
      end
   end

   // read mux; reserved bit 3 and unmapped addresses read zero
   always_comb
   begin
      rd_byte = 8'h00;
      if (haddr_i[9:0] == ADDR_DATA)
         rd_byte = rx_buf;
      else if (haddr_i[9:0] == ADDR_CTRL)
         rd_byte = ctrl;
      else if (haddr_i[9:0] == ADDR_STAT)
         rd_byte = {done_flag, write_collision_flag_flag, ovr_flag, mode_fault_flag_flag, 1'b0, swst};
   end

   // read data register, loaded at the address phase
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         hrdata_o <= 32'h0000_0000;
      else if (acc & ~hwrite_i)
         hrdata_o <= {24'h00_0000, rd_byte};
   end

   // two-flop synchronisers; sck gets a third stage for edge detect
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         {sck_s1, sck_s2, sck_s3} <= 3'h0;
         {mosi_s1, mosi_s2}       <= 2'h0;
         {miso_s1, miso_s2}       <= 2'h0;
         {ss_s1, ss_s2}           <= 2'h3;
      end
      else
      begin
         {sck_s1, sck_s2, sck_s3} <= {sck_i, sck_s1, sck_s2};
         {mosi_s1, mosi_s2}       <= {mosi_i, mosi_s1};
         {miso_s1, miso_s2}       <= {miso_i, miso_s1};
         {ss_s1, ss_s2}           <= {ss_n_i, ss_s1};
      end
   end

   // select source: internal bit or pin, low means selected
   assign sel_n   = swst.sel_mgmt ? swst.sel_int : ss_s2;
   assign slv_act = ctrl.periph_en & ~ctrl.master & ~sel_n;
   assign fault   = ctrl.periph_en & ctrl.master & ~sel_n;

   // baud table; only the master sequencer reads it
   always_comb
   begin
      case ({ctrl.div_dis, ctrl.rate})
         3'b100:  half = HALF_DIV4;
         3'b000:  half = HALF_DIV8;
         3'b001:  half = HALF_DIV16;
         3'b101:  half = HALF_DIV8;
         3'b110:  half = HALF_DIV32;
         3'b010:  half = HALF_DIV64;
         3'b011:  half = HALF_DIV128;
         default: half = HALF_DIV64;
      endcase
   end

   // edge source: own divider in master, synced pin edges in slave
   assign m_tick = (state == ST_RUN) & (div_cnt == half - 7'd1);
   always_comb
   begin
      if (ctrl.master)
      begin
         edge_v    = m_tick;
         edge_lead = (msck == ctrl.clock_polarity_bit);
      end
      else
      begin
         edge_v    = slv_act & (sck_s2 ^ sck_s3);
         edge_lead = (sck_s2 != ctrl.clock_polarity_bit);
      end
   end

   // phase 0 samples on leading edges, phase 1 on trailing
   assign smp   = edge_v & (edge_lead ^ ctrl.clock_phase_bit);
   assign shf   = edge_v & ~(edge_lead ^ ctrl.clock_phase_bit);
   assign rx_in = ctrl.master ? miso_s2 : mosi_s2;
   // master miso crosses two flops, so at /4 the bit launched on the
   // trailing edge is only visible one cycle after the next tick
   assign cap        = ctrl.master ? m_cap : smp;
   assign next_shreg = cap ? {shreg[6:0], rx_in} : shreg;

   // delayed master capture and byte end
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         m_cap <= 1'b0;
         m_fin <= 1'b0;
      end
      else
      begin
         m_cap <= smp & ctrl.master & (state == ST_RUN);
         m_fin <= m_done;
      end
   end

   // byte ends on the last master edge, or eighth slave sample
   assign m_done    = m_tick & (edge_cnt == LAST_EDGE) & ~fault;
   assign s_done    = ~ctrl.master & smp & (smp_cnt == LAST_SAMPLE);
   assign xfer_done = m_fin | s_done;
   assign busy      = (state == ST_RUN) | slv_busy | m_fin;
   assign wr_ok     = wr_data & ~busy & ~(done_flag & ~td_seen);

   // master sequencer and sck generator
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state    <= ST_IDLE;
         div_cnt  <= 7'h00;
         edge_cnt <= 4'h0;
         msck     <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               msck     <= ctrl.clock_polarity_bit;
               div_cnt  <= 7'h00;
               edge_cnt <= 4'h0;
               // a data write in master mode starts the byte
               if (wr_ok & ctrl.master & ctrl.periph_en & ~fault)
                  state <= ST_RUN;
            end
            ST_RUN:
            begin
               if (fault | ~ctrl.master)
                  state <= ST_IDLE;
               else if (m_tick)
               begin
                  div_cnt  <= 7'h00;
                  msck     <= ~msck;
                  edge_cnt <= edge_cnt + 4'h1;
                  if (edge_cnt == LAST_EDGE)
                     state <= ST_IDLE;
               end
               else
                  div_cnt <= div_cnt + 7'h01;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // slave byte tracking; deselect aborts and restarts framing
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         slv_busy <= 1'b0;
      else if (~slv_act | s_done)
         slv_busy <= 1'b0;
      else if (edge_v)
         slv_busy <= 1'b1;
   end

   // shift register, sample counter and output bit
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         shreg   <= DATA_RST;
         smp_cnt <= 3'h0;
         out_bit <= 1'b0;
      end
      else if (wr_ok)
      begin
         shreg   <= hwdata_i[7:0];
         out_bit <= hwdata_i[7];
         smp_cnt <= 3'h0;
      end
      else
      begin
         shreg <= next_shreg;
         if (shf)
            out_bit <= shreg[7];
         if (xfer_done | (~ctrl.master & ~slv_act) | (state == ST_IDLE & ctrl.master))
            smp_cnt <= 3'h0;
         else if (smp)
            smp_cnt <= smp_cnt + 3'h1;
      end
   end

   // receive buffer: only loaded when no earlier byte is pending
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         rx_buf <= DATA_RST;
      else if (xfer_done & ~done_flag)
         rx_buf <= next_shreg;
   end

   // control register; fault clears enable and master, wins over writes
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         ctrl <= CTRL_RST;
      else
      begin
         if (wr_ctrl)
         begin
            ctrl <= sri_ctrl_t'(hwdata_i[7:0]);
            // while faulted these two cannot be set outside clearing
            ctrl.periph_en <= hwdata_i[6] & (~mode_fault_flag_flag | mf_seen);
            ctrl.master    <= hwdata_i[4] & (~mode_fault_flag_flag | mf_seen);
         end
         if (fault)
         begin
            ctrl.periph_en <= 1'b0;
            ctrl.master    <= 1'b0;
         end
      end
   end

   // software bits of status; bit 3 is not stored
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         swst <= SW_STAT_RST;
      else if (wr_stat)
         swst <= sri_swstat_t'(hwdata_i[2:0]);
   end

   // transfer done flag; a new byte wins over the clear
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         done_flag <= 1'b0;
         td_seen   <= 1'b0;
      end
      else if (xfer_done)
      begin
         done_flag <= 1'b1;
         td_seen   <= td_seen & done_flag;
      end
      else if (done_flag & td_seen & (rd_data | wr_data))
      begin
         done_flag <= 1'b0;
         td_seen   <= 1'b0;
      end
      else if (done_flag & stat_acc)
         td_seen <= 1'b1;
   end

   // write collision flag; status only
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         write_collision_flag_flag <= 1'b0;
         wc_seen   <= 1'b0;
      end
      else if (wr_data & busy)
         write_collision_flag_flag <= 1'b1;
      else if (write_collision_flag_flag & wc_seen & rd_data)
      begin
         write_collision_flag_flag <= 1'b0;
         wc_seen   <= 1'b0;
      end
      else if (write_collision_flag_flag & rd_stat)
         wc_seen <= 1'b1;
   end

   // overrun flag; cleared by a status read, a new overrun wins
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         ovr_flag <= 1'b0;
      else if (xfer_done & done_flag)
         ovr_flag <= 1'b1;
      else if (rd_stat)
         ovr_flag <= 1'b0;
   end

   // mode fault flag and its two-step clearing
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         mode_fault_flag_flag <= 1'b0;
         mf_seen   <= 1'b0;
      end
      else if (fault)
      begin
         mode_fault_flag_flag <= 1'b1;
         mf_seen   <= 1'b0;
      end
      else if (mode_fault_flag_flag & mf_seen & wr_ctrl)
      begin
         mode_fault_flag_flag <= 1'b0;
         mf_seen   <= 1'b0;
      end
      else if (mode_fault_flag_flag & stat_acc)
         mf_seen <= 1'b1;
   end

   // collision is deliberately not an interrupt source
   assign irq_o = ctrl.irq_en & (done_flag | mode_fault_flag_flag | ovr_flag);

   // pin drivers; enables released while the peripheral is off
   assign sck_o     = msck;
   assign sck_oe_o  = ctrl.periph_en & ctrl.master;
   assign mosi_o    = out_bit;
   assign mosi_oe_o = ctrl.periph_en & ctrl.master & ~swst.out_dis;
   assign miso_o    = out_bit;
   assign miso_oe_o = slv_act & ~swst.out_dis;

   // checks
   a_irq_on_done: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      xfer_done && ctrl.irq_en && !wr_ctrl |=> irq_o)
      else $error("done with irq enabled gave no request");
   a_fault_drops_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      fault |=> mode_fault_flag_flag && !ctrl.periph_en && !ctrl.master)
      else $error("fault did not clear enable and master");
   a_div4_byte_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(state == ST_RUN) && half == HALF_DIV4 && $stable(half)
      |-> (!fault)[*1] ##31 (m_done || fault))
      else $error("divide by four byte not 16 edges");
   a_done_sets_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      xfer_done |=> done_flag)
      else $error("transfer done flag not set");
   a_blocked_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_data && done_flag && !td_seen && state == ST_IDLE |=> state == ST_IDLE)
      else $error("write started a byte while done was pending");
   a_write_collision_flag_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_data && busy |=> write_collision_flag_flag && ($stable(shreg[6:0]) || $past(cap)))
      else $error("collision not flagged");
   a_ovr_keeps_buf: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      xfer_done && done_flag |=> ovr_flag && $stable(rx_buf))
      else $error("overrun lost flag or buffer");
   a_ovr_read_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_stat && !xfer_done |=> !ovr_flag)
      else $error("status read did not clear overrun");
   a_fault_refuse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_ctrl && mode_fault_flag_flag && !mf_seen |=> !ctrl.periph_en && !ctrl.master)
      else $error("enable set while fault pending");
   a_sck_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state == ST_IDLE && $past(state) == ST_IDLE && $stable(ctrl.clock_polarity_bit)
      |-> sck_o == ctrl.clock_polarity_bit)
      else $error("sck not at idle level");

   c_master_byte: cover property (@(posedge clk_i) disable iff (sys_rst_i) m_done);
   c_slave_byte:  cover property (@(posedge clk_i) disable iff (sys_rst_i) s_done);
   c_overrun:     cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(ovr_flag));
   c_mode_fault:  cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(mode_fault_flag_flag));

endmodule

// file: tb/sri_peer.sv
// behavioural spi slave facing the core in master mode, clock idle low, phase zero
`timescale 1ns/1ps
module sri_peer
(
   input  wire logic       sck_i,
   input  wire logic       mosi_i,
   input  wire logic [7:0] load_i,
   input  wire logic       load_en_i,
   output logic            miso_o,
   output logic [7:0]      rx_o
);
   logic [7:0] tx;   // outgoing byte, msb on the line

   // capture on leading edge, msb arrives first
   always @(posedge sck_i)
      rx_o <= {rx_o[6:0], mosi_i};

   // shift on trailing edge; load is taken while the clock is idle
   always @(negedge sck_i or posedge load_en_i)
      if (load_en_i)
         tx <= load_i;
      else
         tx <= {tx[6:0], ~tx[7]};

   assign miso_o = tx[7];
endmodule

// file: tb/test_sri_core.sv
// self-checking bench for the spi register interface
`timescale 1ns/1ps
module test_sri_core;
   import sri_pkg::*;
   logic        clk_i, sys_rst_i, hsel, hwrite, hready;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic        sck, sck_oe, mosi, mosi_oe, miso_o, miso_oe, irq, resp, miso;
   logic [7:0]  pbyte, prx, r;
   logic        pld;
   int          miscompares, n_checks, cnt;
   // ordinary cases: address, value written, value read back
   logic [9:0]  ra [5] = '{ADDR_CTRL, ADDR_STAT, 10'h100, ADDR_STAT, ADDR_CTRL};
   logic [7:0]  rd [5] = '{8'h2F, 8'h06, 8'hFF, 8'h00, 8'h00};
   logic [7:0]  re [5] = '{8'h2F, 8'h06, 8'h00, 8'h00, 8'h00};
   // master rate codes and half periods in cpu clocks
   logic [2:0]  code [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
   int          half [6] = '{2, 4, 8, 16, 32, 64};

   sri_core i_sri_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(resp), .sck_i(1'b0), .sck_o(sck), .sck_oe_o(sck_oe), .mosi_i(1'b0),
      .mosi_o(mosi), .mosi_oe_o(mosi_oe), .miso_i(miso), .miso_o(miso_o),
      .miso_oe_o(miso_oe), .ss_n_i(1'b1), .irq_o(irq));

   sri_peer i_sri_peer (.sck_i(sck), .mosi_i(mosi), .load_i(pbyte), .load_en_i(pld),
      .miso_o(miso), .rx_o(prx));

   // free-running cpu clock, 25 ns
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // one compare, mismatches reported at once
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // single ahb-lite word transfer; slave may stretch either phase
   task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_i);
      hsel <= 1'b1;
      haddr <= {22'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk_i); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge clk_i); while (hready !== 1'b1);
      r = hrdata[7:0];
   endtask

   task automatic wrap_up;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // a hang counts as a mismatch
   initial
   begin
      #(25 * 40000);
      miscompares++;
      wrap_up();
   end

   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata, pld, pbyte} = '0;
      miscompares = 0;
      n_checks = 0;
      sys_rst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      // table rows: write then read back
      for (int i = 0; i < 5; i++)
      begin
         bus(ra[i], 1'b1, rd[i]);
         bus(ra[i], 1'b0, 8'h00);
         chk(r, re[i]);
      end
      // second reset in mid-run
      bus(ADDR_CTRL, 1'b1, 8'h2F);
      sys_rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      bus(ADDR_CTRL, 1'b0, 8'h00);
      chk(r & 8'hF0, 8'h00);
      bus(ADDR_STAT, 1'b0, 8'h00);
      chk(r, 8'h00);
      // one master byte for each of six rate codes, a second data write collides
      bus(ADDR_STAT, 1'b1, 8'h03);
      for (int k = 0; k < 6; k++)
      begin
         bus(ADDR_CTRL, 1'b1, {2'b11, code[k][2], 3'b100, code[k][1:0]});
         #1;
         chk({sck, sck_oe}, 8'h01);
         pbyte <= 8'hA5 ^ 8'(k);
         pld <= 1'b1;
         @(posedge clk_i);
         pld <= 1'b0;
         bus(ADDR_DATA, 1'b1, 8'h3C + 8'(k));
         bus(ADDR_DATA, 1'b1, 8'hFF);
         cnt = 0;
         while (irq !== 1'b1 && cnt < 3000)
         begin
            @(posedge clk_i);
            #1;
            cnt++;
         end
         chk(cnt >= 16 * half[k] - 2 && cnt <= 16 * half[k] + 1, 8'h01);
         chk(prx, 8'h3C + 8'(k));
         bus(ADDR_STAT, 1'b0, 8'h00);
         chk(r, 8'hC3);
         bus(ADDR_DATA, 1'b0, 8'h00);
         chk(r, 8'hA5 ^ 8'(k));
         bus(ADDR_STAT, 1'b0, 8'h00);
         chk(r, 8'h03);
         chk({7'h0, irq}, 8'h00);
      end
      // mode fault: internal select low while master
      bus(ADDR_STAT, 1'b1, 8'h02);
      bus(ADDR_CTRL, 1'b1, 8'hD0);
      repeat (3) @(posedge clk_i);
      bus(ADDR_CTRL, 1'b0, 8'h00);
      chk(r, 8'h80);
      bus(ADDR_CTRL, 1'b1, 8'hD0);
      bus(ADDR_CTRL, 1'b0, 8'h00);
      chk(r, 8'h80);
      bus(ADDR_STAT, 1'b0, 8'h00);
      chk({r[7:1], irq}, 8'h13);
      bus(ADDR_STAT, 1'b1, 8'h07);
      bus(ADDR_CTRL, 1'b1, 8'h50);
      bus(ADDR_STAT, 1'b0, 8'h00);
      chk(r, 8'h07);
      chk({sck_oe, mosi_oe}, 8'h02);
      wrap_up();
   end
endmodule
